/* File: rtl/afd_pkg.sv */
/*
 * constants shared by the fast-detect and overrange block: register offsets,
 * field widths, reset values and cycle figures.
 * assumes an 8-bit register port with a 12-bit address, decoded elsewhere.
 */
package afd_pkg;

	// register offsets
	localparam logic [11:0] ADDR_UPPER_LO = 12'h247;
	localparam logic [11:0] ADDR_UPPER_HI = 12'h248;
	localparam logic [11:0] ADDR_LOWER_LO = 12'h249;
	localparam logic [11:0] ADDR_LOWER_HI = 12'h24a;
	localparam logic [11:0] ADDR_DWELL_LO = 12'h24b;
	localparam logic [11:0] ADDR_DWELL_HI = 12'h24c;
	localparam logic [11:0] ADDR_OVR_CLR  = 12'h562;
	localparam logic [11:0] ADDR_OVR_STAT = 12'h563;

	// field widths
	localparam int SAMPLE_W = 14;
	localparam int THR_W    = 13;
	localparam int THR_HI_W = THR_W - 8;
	localparam int DWELL_W  = 16;
	localparam int NUM_CH   = 2;
	localparam int NUM_VC   = 8;

	// values after reset
	localparam logic [THR_W-1:0]   UPPER_RST = 13'h1fff;
	localparam logic [THR_W-1:0]   LOWER_RST = 13'h0000;
	localparam logic [DWELL_W-1:0] DWELL_RST = 16'h0001;
	localparam logic [7:0]         CLR_RST   = 8'h00;
	localparam logic [NUM_VC-1:0]  STAT_RST  = 8'h00;

	// cycle figures
	localparam int UPPER_LAT_MAX = 28;
	localparam int PIPE_LAT_DEF  = 4;

endpackage : afd_pkg

/* File: rtl/afd_delay.sv */
/*
 * fixed-length delay line, used to keep the overrange indicator and the
 * sample it describes in step.
 * assumes D is at least one.
 */
`timescale 1ns/1ps
module afd_delay #(
	parameter int W = 1,
	parameter int D = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	import afd_pkg::*;

	logic [W-1:0] stage [D];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			for (int i = 0; i < D; i++) begin
				stage[i] <= '0;
			end
		end else begin
			stage[0] <= din;
			for (int i = 1; i < D; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign dout = stage[D-1];

endmodule : afd_delay

/* File: rtl/afd_chan_detect.sv */
/*
 * one channel of fast threshold detection: magnitude, upper and lower
 * comparison, dwell counter and the flag.
 * assumes one sample per clock and thresholds that change only rarely.
 */
`timescale 1ns/1ps
module afd_chan_detect (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// converter output
	input  wire logic [afd_pkg::SAMPLE_W-1:0] sample,
	// settings
	input  wire logic [afd_pkg::THR_W-1:0]    upper,
	input  wire logic [afd_pkg::THR_W-1:0]    lower,
	input  wire logic [afd_pkg::DWELL_W-1:0]  dwell,
	// flag
	output logic                               flag
);
	import afd_pkg::*;

	localparam int LAT_BOUND = UPPER_LAT_MAX;

	logic [SAMPLE_W-1:0] mag_now;
	logic [SAMPLE_W-1:0] mag;
	logic                above;
	logic                below;
	logic [DWELL_W-1:0]  cnt;

	// two's complement negate; the most negative code lands on 2^13 exactly
	assign mag_now = sample[SAMPLE_W-1] ? SAMPLE_W'(~sample + 1'b1) : sample;
	assign above   = mag > {1'b0, upper};
	assign below   = mag < {1'b0, lower};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mag <= '0;
		end else begin
			mag <= mag_now;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag <= 1'b0;
		end else if (above) begin
			flag <= 1'b1;
		end else if (flag && below && cnt >= dwell) begin
			flag <= 1'b0;
		end
	end

	// strictly more than dwell samples below the lower threshold clear the flag
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt <= '0;
		end else if (!flag || above || !below) begin
			cnt <= '0;
		end else if (cnt != '1) begin
			cnt <= cnt + 1'b1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_flag_rise_latency: assert property (
		(mag_now > {1'b0, upper}) && $stable(upper) |-> ##[1:LAT_BOUND] flag
	) else $error("flag missed an upper crossing");

	chk_flag_set_next: assert property (
		above |=> flag
	) else $error("flag not set after upper crossing");

	chk_flag_fall_cause: assert property (
		$fell(flag) |-> $past(below) && ($past(cnt) >= $past(dwell))
	) else $error("flag cleared without a full dwell below lower");

	chk_count_restart: assert property (
		flag && !below |=> cnt == '0
	) else $error("dwell count did not restart");

	chk_flag_hold: assert property (
		flag && !below |=> flag
	) else $error("flag dropped while not below lower");

endmodule : afd_chan_detect

/* File: rtl/afd_top.sv */
/*
 * fast threshold detection and overrange handling for a dual converter:
 * register file, two detection channels, aligned overrange and sticky status.
 * assumes the serial control port is decoded outside into single-cycle
 * register read and write strobes, and one sample per clock per channel.
 */
`timescale 1ns/1ps
module afd_top #(
	parameter int PIPE_LAT = afd_pkg::PIPE_LAT_DEF
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// register port
	input  wire logic [11:0]                   reg_addr,
	input  wire logic [7:0]                    reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [7:0]                    reg_rdata,
	// converter core
	input  wire logic [afd_pkg::SAMPLE_W-1:0] sample_one,
	input  wire logic [afd_pkg::SAMPLE_W-1:0] sample_two,
	input  wire logic [afd_pkg::NUM_CH-1:0]   ovr_in,
	input  wire logic [afd_pkg::NUM_VC-1:0]   vc_ovr,
	// aligned sample stream
	output logic      [afd_pkg::SAMPLE_W-1:0] sample_one_out,
	output logic      [afd_pkg::SAMPLE_W-1:0] sample_two_out,
	output logic      [afd_pkg::NUM_CH-1:0]   ovr_out,
	// fast threshold flags
	output logic                               threshold_flag_channel_one,
	output logic                               threshold_flag_channel_two
);
	import afd_pkg::*;

	logic [THR_W-1:0]    upper;
	logic [THR_W-1:0]    lower;
	logic [DWELL_W-1:0]  dwell;
	logic [7:0]          clr_ctrl;
	logic [NUM_VC-1:0]   ovr_stat;
	logic [NUM_VC-1:0]   clr_fall;
	logic [7:0]          next_rdata;
	logic [SAMPLE_W-1:0] samp [NUM_CH];
	logic [NUM_CH-1:0]   flag;
	logic [SAMPLE_W-1:0] chk_mag [NUM_CH];
	logic [NUM_CH-1:0]   over_thr;
	logic [15:0]         warm_cnt;
	logic                warm;

	assign samp[0] = sample_one;
	assign samp[1] = sample_two;

	// register writes

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			upper <= UPPER_RST;
		end else if (reg_wr && reg_addr == ADDR_UPPER_LO) begin
			upper[7:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == ADDR_UPPER_HI) begin
			upper[THR_W-1:8] <= reg_wdata[THR_HI_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lower <= LOWER_RST;
		end else if (reg_wr && reg_addr == ADDR_LOWER_LO) begin
			lower[7:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == ADDR_LOWER_HI) begin
			lower[THR_W-1:8] <= reg_wdata[THR_HI_W-1:0];
		end
	end

	// a dwell of zero behaves as one clear-after-first-below; software is
	// expected to keep it within 1..65535
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dwell <= DWELL_RST;
		end else if (reg_wr && reg_addr == ADDR_DWELL_LO) begin
			dwell[7:0] <= reg_wdata;
		end else if (reg_wr && reg_addr == ADDR_DWELL_HI) begin
			dwell[15:8] <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clr_ctrl <= CLR_RST;
		end else if (reg_wr && reg_addr == ADDR_OVR_CLR) begin
			clr_ctrl <= reg_wdata;
		end
	end

	// clear acts on the one-to-zero step of the control bit
	assign clr_fall = clr_ctrl & ~(reg_wr && reg_addr == ADDR_OVR_CLR ? reg_wdata : clr_ctrl);

	// sticky overrange status; a new overrange beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ovr_stat <= STAT_RST;
		end else begin
			ovr_stat <= (ovr_stat & ~clr_fall) | vc_ovr;
		end
	end

	// register reads, answered one clock after the strobe

	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_addr)
			ADDR_UPPER_LO: next_rdata = upper[7:0];
			ADDR_UPPER_HI: next_rdata = {3'h0, upper[THR_W-1:8]};
			ADDR_LOWER_LO: next_rdata = lower[7:0];
			ADDR_LOWER_HI: next_rdata = {3'h0, lower[THR_W-1:8]};
			ADDR_DWELL_LO: next_rdata = dwell[7:0];
			ADDR_DWELL_HI: next_rdata = dwell[15:8];
			ADDR_OVR_CLR:  next_rdata = clr_ctrl;
			ADDR_OVR_STAT: next_rdata = ovr_stat;
			default:       next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// detection channels, all sharing one set of thresholds

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		afd_chan_detect u_det (
			.clk    (clk),
			.rst_n  (rst_n),
			.sample (samp[c]),
			.upper  (upper),
			.lower  (lower),
			.dwell  (dwell),
			.flag   (flag[c])
		);
		// check-side magnitude, worked out apart from the channel's own datapath
		assign chk_mag[c]  = samp[c][SAMPLE_W-1] ? SAMPLE_W'(-samp[c]) : samp[c];
		assign over_thr[c] = chk_mag[c] > {1'b0, upper};
	end

	assign threshold_flag_channel_one = flag[0];
	assign threshold_flag_channel_two = flag[1];

	// overrange indicator travels with its sample through equal delay lines,
	// so downstream framing sees both in the same cycle

	afd_delay #(
		.W (2 * SAMPLE_W),
		.D (PIPE_LAT)
	) u_samp_dly (
		.clk   (clk),
		.rst_n (rst_n),
		.din   ({sample_two, sample_one}),
		.dout  ({sample_two_out, sample_one_out})
	);

	afd_delay #(
		.W (NUM_CH),
		.D (PIPE_LAT)
	) u_ovr_dly (
		.clk   (clk),
		.rst_n (rst_n),
		.din   (ovr_in),
		.dout  (ovr_out)
	);

	// alignment checks look back PIPE_LAT samples, so they hold off that long
	// after reset, while the delay lines still carry reset zeros
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			warm_cnt <= '0;
		end else if (!warm) begin
			warm_cnt <= warm_cnt + 16'h0001;
		end
	end

	assign warm = warm_cnt >= 16'(PIPE_LAT);

	// checks

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_sticky_set: assert property (
		vc_ovr != '0 |=> (ovr_stat & $past(vc_ovr)) == $past(vc_ovr)
	) else $error("overrange not latched");

	chk_sticky_hold: assert property (
		clr_fall == '0 |=> (ovr_stat & $past(ovr_stat)) == $past(ovr_stat)
	) else $error("sticky status lost without a clear");

	// a bit whose overrange repeats in the clearing cycle is left set
	chk_clear_seq: assert property (
		clr_fall != '0 |=> (ovr_stat & $past(clr_fall & ~vc_ovr)) == '0
	) else $error("clear sequence did not clear status");

	chk_ovr_aligned: assert property (
		warm |->
		ovr_out == $past(ovr_in, PIPE_LAT) &&
		sample_one_out == $past(sample_one, PIPE_LAT) &&
		sample_two_out == $past(sample_two, PIPE_LAT)
	) else $error("overrange not aligned with sample");

	chk_ovr_raise: assert property (
		ovr_in[0] |-> ##PIPE_LAT ovr_out[0]
	) else $error("overrange indicator not raised");

	chk_ovr_raise_two: assert property (
		ovr_in[1] |-> ##PIPE_LAT ovr_out[1]
	) else $error("overrange indicator two not raised");

	chk_dwell_write: assert property (
		reg_wr && reg_addr == ADDR_DWELL_HI |=> dwell[15:8] == $past(reg_wdata)
	) else $error("dwell high byte not written");

	chk_upper_read: assert property (
		reg_rd && reg_addr == ADDR_UPPER_HI && !reg_wr
		|=> reg_rdata == {3'h0, upper[THR_W-1:8]}
	) else $error("upper threshold high byte misread");

	chk_lower_width: assert property (
		reg_wr && reg_addr == ADDR_LOWER_HI
		|=> lower[THR_W-1:8] == $past(reg_wdata[THR_HI_W-1:0])
	) else $error("lower threshold high bits not written");

	chk_stat_read: assert property (
		reg_rd && reg_addr == ADDR_OVR_STAT |=> reg_rdata == $past(ovr_stat)
	) else $error("status read does not show sticky bits");

	chk_stat_readonly: assert property (
		reg_wr && reg_addr == ADDR_OVR_STAT && vc_ovr == '0 |=> $stable(ovr_stat)
	) else $error("status changed on a write to it");

	chk_upper_write: assert property (
		reg_wr && reg_addr == ADDR_UPPER_LO |=> upper[7:0] == $past(reg_wdata)
	) else $error("upper threshold low byte not written");

	chk_lower_write: assert property (
		reg_wr && reg_addr == ADDR_LOWER_LO |=> lower[7:0] == $past(reg_wdata)
	) else $error("lower threshold low byte not written");

	chk_dwell_low: assert property (
		reg_wr && reg_addr == ADDR_DWELL_LO |=> dwell[7:0] == $past(reg_wdata)
	) else $error("dwell low byte not written");

	chk_lower_read: assert property (
		reg_rd && reg_addr == ADDR_LOWER_HI && !reg_wr
		|=> reg_rdata == {3'h0, lower[THR_W-1:8]}
	) else $error("lower threshold high byte misread");

	chk_dwell_read: assert property (
		reg_rd && reg_addr == ADDR_DWELL_LO && !reg_wr
		|=> reg_rdata == dwell[7:0]
	) else $error("dwell low byte misread");

	chk_clr_readback: assert property (
		reg_rd && reg_addr == ADDR_OVR_CLR && !reg_wr |=> reg_rdata == clr_ctrl
	) else $error("clear control does not read back");

	chk_rdata_hold: assert property (
		!reg_rd |=> $stable(reg_rdata)
	) else $error("read data changed without a read");

	// flag checks against a magnitude worked out here, so a fault in a
	// channel's own arithmetic or in the output wiring cannot hide itself
	chk_flags_apart: assert property (
		$rose(threshold_flag_channel_one) && $past(upper) == $past(upper, 2)
		|-> $past(over_thr[0], 2)
	) else $error("flag one rose without a crossing on its own channel");

	chk_flag_two_cause: assert property (
		$rose(threshold_flag_channel_two) && $past(upper) == $past(upper, 2)
		|-> $past(over_thr[1], 2)
	) else $error("flag two rose without a crossing on its own channel");

	chk_flag_one_time: assert property (
		over_thr[0] ##1 $stable(upper) |=> threshold_flag_channel_one
	) else $error("flag one late after an upper crossing");

	chk_flag_two_time: assert property (
		over_thr[1] ##1 $stable(upper) |=> threshold_flag_channel_two
	) else $error("flag two late after an upper crossing");

endmodule : afd_top

/* File: sim/afd_gain_model.sv */
/*
 * receiver gain-control stand-in: counts how often each fast-detect flag rises,
 * the moments at which a real loop would cut the gain.
 * assumes the flags are registered and the clock runs continuously.
 */
`timescale 1ns/1ps
module afd_gain_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// flags watched
	input  wire logic       flag_one,
	input  wire logic       flag_two,
	// gain-cut requests seen
	output logic      [7:0] cuts_one,
	output logic      [7:0] cuts_two
);
	logic prev_one;
	logic prev_two;

	// only rising flags count, so a flag held high asks for one cut only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prev_one <= 1'b0;
			prev_two <= 1'b0;
			cuts_one <= 8'h00;
			cuts_two <= 8'h00;
		end else begin
			prev_one <= flag_one;
			prev_two <= flag_two;
			cuts_one <= cuts_one + 8'(flag_one & ~prev_one);
			cuts_two <= cuts_two + 8'(flag_two & ~prev_two);
		end
	end
endmodule : afd_gain_model

/* File: sim/test_adc_fast_detect_overrange.sv */
/*
 * testbench for the fast-detect and overrange block: register port tasks,
 * threshold and dwell sequences, delay alignment and sticky status clearing.
 * assumes the register strobes are single-cycle and samples come every clock.
 */
`timescale 1ns/1ps
module test_adc_fast_detect_overrange;
	import afd_pkg::*;
	localparam int LAT = 3;
	localparam logic [13:0] MID = 14'h0900, BELOW = 14'h0100, EQ = 14'h0800;
	logic              clk, rst_n, reg_wr, reg_rd, f1, f2;
	logic [11:0]       reg_addr;
	logic [7:0]        reg_wdata, reg_rdata, r1, r2;
	logic [13:0]       s1, s2, o1, o2;
	logic [1:0]        ovr_in, ovr_out;
	logic [7:0]        vc_ovr;
	int                mismatches, checks, cycles, n;

	afd_top #(.PIPE_LAT(LAT)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sample_one(s1), .sample_two(s2), .ovr_in(ovr_in), .vc_ovr(vc_ovr),
		.sample_one_out(o1), .sample_two_out(o2), .ovr_out(ovr_out),
		.threshold_flag_channel_one(f1), .threshold_flag_channel_two(f2));
	afd_gain_model gain_u (.clk(clk), .rst_n(rst_n), .flag_one(f1), .flag_two(f2),
		.cuts_one(r1), .cuts_two(r2));

	task automatic final_report();
		if (mismatches == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic cmp_flag(string what, logic exp, logic got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp_flag

	// every cycle: the overrange bit must ride with the sample it came with
	task automatic step();
		@(posedge clk);
		#1;
		cmp("ovr_out", 16'({o2[0], o1[0]}), 16'(ovr_out));
	endtask : step

	task automatic drive(logic [13:0] a, logic [13:0] b, int hold);
		step();
		s1 = a;
		s2 = b;
		ovr_in = {b[0], a[0]};
		repeat (hold - 1) step();
	endtask : drive

	task automatic reg_write(logic [11:0] a, logic [7:0] d);
		step();
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		step();
		reg_wr = 1'b0;
	endtask : reg_write

	task automatic reg_read(logic [11:0] a, logic [7:0] exp);
		step();
		reg_addr = a;
		reg_rd = 1'b1;
		step();
		reg_rd = 1'b0;
		cmp("reg_rdata", 16'(exp), 16'(reg_rdata));
	endtask : reg_read

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ceiling well above the roughly 120 cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			final_report();
		end
	end

	initial begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, s1, s2, ovr_in, vc_ovr} = '0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		reg_read(ADDR_UPPER_LO, UPPER_RST[7:0]);
		reg_read(ADDR_UPPER_HI, 8'(UPPER_RST[12:8]));
		reg_read(ADDR_LOWER_LO, LOWER_RST[7:0]);
		reg_read(ADDR_DWELL_LO, DWELL_RST[7:0]);
		reg_read(ADDR_DWELL_HI, DWELL_RST[15:8]);
		reg_read(ADDR_OVR_STAT, STAT_RST);
		reg_read(12'h000, 8'h00);
		reg_write(ADDR_LOWER_HI, 8'hff);
		reg_read(ADDR_LOWER_HI, 8'h1f);
		reg_write(ADDR_OVR_STAT, 8'hff);
		reg_read(ADDR_OVR_STAT, 8'h00);
		reg_write(ADDR_UPPER_LO, 8'hff);
		reg_write(ADDR_UPPER_HI, 8'h0f);
		reg_write(ADDR_LOWER_LO, 8'h00);
		reg_write(ADDR_LOWER_HI, 8'h08);
		reg_write(ADDR_DWELL_LO, 8'h02);
		reg_write(ADDR_DWELL_HI, 8'h00);
		reg_read(ADDR_DWELL_LO, 8'h02);
		drive(14'h0234, 14'h3dcb, 1);
		n = 0;
		while (o1 !== 14'h0234 && n < 40) begin
			step();
			n++;
		end
		cmp("sample delay", 16'(LAT), 16'(n));
		cmp("sample_two_out", 16'h3dcb, 16'(o2));
		drive(14'h0fff, 14'h0000, 6);
		cmp_flag("flag one", 1'b0, f1);
		drive(14'h1000, 14'h0000, 1);
		n = 0;
		while (f1 !== 1'b1 && n < UPPER_LAT_MAX) begin
			step();
			n++;
		end
		cmp_flag("flag one", 1'b1, f1);
		cmp("flag latency", 16'h0002, 16'(n));
		cmp_flag("flag two", 1'b0, f2);
		drive(MID, 14'h3000, 6);
		cmp_flag("flag two", 1'b1, f2);
		cmp_flag("flag one", 1'b1, f1);
		drive(BELOW, -BELOW, 2);
		drive(MID, -MID, 6);
		cmp_flag("flag one", 1'b1, f1);
		drive(BELOW, -BELOW, 2);
		drive(EQ, -EQ, 1);
		drive(BELOW, -BELOW, 2);
		drive(MID, -MID, 6);
		cmp_flag("flag one", 1'b1, f1);
		cmp_flag("flag two", 1'b1, f2);
		drive(BELOW, -BELOW, 3);
		drive(MID, -MID, 6);
		cmp_flag("flag one", 1'b0, f1);
		cmp_flag("flag two", 1'b0, f2);
		cmp("cuts one", 16'h0001, 16'(r1));
		cmp("cuts two", 16'h0001, 16'(r2));
		step();
		vc_ovr = 8'h48;
		step();
		vc_ovr = 8'h00;
		reg_read(ADDR_OVR_STAT, 8'h48);
		reg_write(ADDR_OVR_CLR, 8'h08);
		reg_read(ADDR_OVR_CLR, 8'h08);
		reg_read(ADDR_OVR_STAT, 8'h48);
		reg_write(ADDR_OVR_CLR, 8'h00);
		reg_read(ADDR_OVR_STAT, 8'h40);
		reg_write(ADDR_OVR_CLR, 8'h00);
		reg_read(ADDR_OVR_STAT, 8'h40);
		reg_write(ADDR_OVR_CLR, 8'h40);
		step();
		{reg_addr, reg_wdata, reg_wr, vc_ovr} = {ADDR_OVR_CLR, 8'h00, 1'b1, 8'h40};
		step();
		{reg_wr, vc_ovr} = '0;
		reg_read(ADDR_OVR_STAT, 8'h40);
		step();
		vc_ovr = 8'hff;
		step();
		vc_ovr = 8'h00;
		reg_read(ADDR_OVR_STAT, 8'hff);
		reg_write(ADDR_OVR_CLR, 8'hff);
		reg_write(ADDR_OVR_CLR, 8'h00);
		reg_read(ADDR_OVR_STAT, 8'h00);
		final_report();
	end
endmodule : test_adc_fast_detect_overrange
